// *** design/sfwp_ctrl.sv ***
// serial flash command, protection and busy control
//
// Behaviour
// RL1: serial link works in clock-idle-low and clock-idle-high modes alike.
// RL2: input sampled on rising serial clock, output changed on falling edge.
// RL3: master sends write enable, then program opcode, address and data.
// RL4: one program writes up to 256 bytes within one page, ones to zeros.
// RL5: sector, block and chip erase return bytes to ones, each timed.
// RL6: program, erase and status write refused while write latch clear.
// RL7: write latch cleared at reset, disable, and end of modifying cycles.
// RL8: busy bit set through status write, program and erase cycles.
// RL9: status read shows the current write latch.
// RL10: device active while selected or while an internal cycle runs.
// RL11: deep sleep ignores everything except the wake instruction.
// RL12: three protect size bits make an upper array region read-only.
// RL13: status lock bit with protect pin low freezes non-volatile bits.
// RL14: in OTP mode lock bit, once set, refuses OTP program and erase.
// RL15: status write in OTP mode ignores data and sets the lock bit.
// RL16: master clears protection, enters OTP, programs, locks, then leaves.
// RL17: modifying instructions run only if clock count is a multiple of 8.
// RL18: array is 512 sectors of 4 KB, sixteen per block, 32 blocks.
// RL19: opcode first, all fields shifted most significant bit first.
// RL20: array instructions during an internal cycle are ignored.
// RL21: program or erase into a protected area starts no cycle.
// RL22: program data past the page end wraps inside the same page.
`timescale 1ns/1ns
`default_nettype none
module sfwp_ctrl
    import sfwp_pkg::*;
#(
    parameter int PROG_CYC = PROGRAM_CYC,
    parameter int SE_CYC = SECTOR_ERASE_CYC,
    parameter int BE_CYC = BLOCK_ERASE_CYC,
    parameter int CE_CYC = CHIP_ERASE_CYC,
    parameter int STATUS_WRITE_CMD_CYC = STATUS_WRITE_CYC
)(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic serial_in,
    input wire logic wp_n,
    output logic serial_out,
    output logic serial_out_en,
    output logic arr_wr_en,
    output logic [ADDR_W-1:0] arr_addr,
    output logic [7:0] arr_wr_data,
    output logic arr_erase,
    output logic [1:0] arr_erase_kind,
    output logic arr_otp,
    output logic busy_flag,
    output logic active_mode,
    output logic deep_sleep
);
    // link side, clocked by the serial clock
    logic link_rst_n;
    logic started;
    logic [2:0] bit_cnt;
    logic [9:0] byte_cnt;
    logic [6:0] sh;
    logic [7:0] fr_op;
    logic [23:0] fr_addr;
    logic frame_tog;
    logic [2:0] next_bit_cnt;
    logic [9:0] next_byte_cnt;
    logic [6:0] next_sh;
    logic [7:0] next_op;
    logic [23:0] next_fr_addr;
    logic next_tog;
    logic [2:0] eff_bit;
    logic [9:0] eff_byte;
    logic [7:0] byte_in;
    logic byte_end;
    logic buf_we;
    logic [7:0] buf_idx;
    logic [7:0] page_buf [PAGE_BYTES];
    logic [8:0] stat_s;
    logic next_so;
    logic next_so_en;

    // system side
    logic wp_s;
    logic tog_s;
    logic cs_s;
    logic cs_d;
    logic seen_tog;
    logic frame_done;
    sfwp_state_e state;
    sfwp_state_e next_state;
    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic write_enable_latch;
    logic next_wel;
    logic [2:0] psize;
    logic [2:0] next_psize;
    logic status_lock_bit;
    logic next_srp;
    logic otp_lock;
    logic next_lock;
    logic next_otp;
    logic next_deep;
    logic pend_sr;
    logic next_pend_sr;
    logic [7:0] sr_data;
    logic [7:0] next_sr_data;
    logic [7:0] idx;
    logic [7:0] next_idx;
    logic [8:0] left;
    logic [8:0] next_left;
    logic [12:0] base;
    logic [12:0] next_base;
    logic next_wr_en;
    logic [ADDR_W-1:0] next_addr;
    logic [7:0] next_wr_data;
    logic next_erase;
    logic [1:0] next_kind;
    logic [7:0] status;
    logic [7:0] next_status;
    logic hw_locked;
    logic aligned;
    logic write_ok;
    logic area_prot;
    logic is_erase;
    logic [1:0] er_kind;
    logic [9:0] er_bytes;
    logic [31:0] er_cyc;
    logic er_prot;
    logic [9:0] data_bytes;

    assign link_rst_n = rst_n & ~cs_n;

    always_comb
    begin
        eff_bit = started ? bit_cnt : 3'h0;
        eff_byte = started ? byte_cnt : 10'h000;
        byte_in = {sh, serial_in};                          // RL19
        byte_end = (eff_bit == 3'h7);
        next_bit_cnt = eff_bit + 3'h1;
        next_sh = byte_in[6:0];
        next_byte_cnt = eff_byte;
        if (byte_end && eff_byte != BYTES_MAX)
        begin
            next_byte_cnt = eff_byte + 10'h001;
        end
        next_op = fr_op;
        if (byte_end && eff_byte == 10'h000)
        begin
            next_op = byte_in;
        end
        next_fr_addr = fr_addr;
        if (byte_end && eff_byte != 10'h000 && eff_byte <= 10'h003)
        begin
            next_fr_addr = {fr_addr[15:0], byte_in};
        end
        next_tog = started ? frame_tog : ~frame_tog;
        buf_we = byte_end && eff_byte >= BYTES_PP_HEADER
            && !stat_s[BIT_BUSY];                           // RL20
        buf_idx = fr_addr[7:0] + eff_byte[7:0] - 8'h04;     // RL22
        // edges while deselected leave the frame alone
        if (cs_n)
        begin
            next_bit_cnt = bit_cnt;
            next_byte_cnt = byte_cnt;
            next_sh = sh;
            next_op = fr_op;
            next_fr_addr = fr_addr;
            next_tog = frame_tog;
            buf_we = 1'b0;
        end
    end

    // framing restarts with every select
    always_ff @(posedge sclk or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            started <= 1'b0;
        end
        else
        begin
            started <= 1'b1;
        end
    end

    // sampled on rising edges in both modes
    always_ff @(posedge sclk or negedge rst_n)                 // RL1 RL2
    begin
        if (!rst_n)
        begin
            bit_cnt <= 3'h0;
            byte_cnt <= 10'h000;
            sh <= 7'h00;
            fr_op <= 8'h00;
            fr_addr <= 24'h00_0000;
            frame_tog <= 1'b0;
        end
        else
        begin
            bit_cnt <= next_bit_cnt;
            byte_cnt <= next_byte_cnt;
            sh <= next_sh;
            fr_op <= next_op;
            fr_addr <= next_fr_addr;
            frame_tog <= next_tog;
        end
    end

    always_ff @(posedge sclk)
    begin
        if (buf_we)
        begin
            page_buf[buf_idx] <= byte_in;                    // RL4
        end
    end

    sfwp_sync #(.W(9)) u_stat_sync (
        .clk(sclk),
        .rst_n(rst_n),
        .din({deep_sleep, status}),
        .dout(stat_s)
    );

    always_comb
    begin
        next_so = 1'b0;
        next_so_en = 1'b0;
        if (started && fr_op == OP_READ_STATUS && byte_cnt != 10'h000
            && !stat_s[8])                                    // RL11
        begin
            next_so_en = 1'b1;
            next_so = stat_s[3'h7 - bit_cnt];                 // RL9 RL19
        end
    end

    // output launched on falling edges
    always_ff @(negedge sclk or negedge link_rst_n)            // RL2
    begin
        if (!link_rst_n)
        begin
            serial_out <= 1'b0;
            serial_out_en <= 1'b0;
        end
        else
        begin
            serial_out <= next_so;
            serial_out_en <= next_so_en;
        end
    end

    sfwp_sync #(.W(3)) u_pin_sync (
        .clk(mclk),
        .rst_n(rst_n),
        .din({wp_n, frame_tog, cs_n}),
        .dout({wp_s, tog_s, cs_s})
    );

    // frame with clocks just ended; link fields now stand still
    assign frame_done = cs_s & ~cs_d & (tog_s != seen_tog);
    assign hw_locked = status_lock_bit & ~wp_s;
    assign aligned = (bit_cnt == 3'h0);                       // RL17
    assign write_ok = aligned & write_enable_latch;                          // RL6
    assign data_bytes = byte_cnt - BYTES_PP_HEADER;
    assign area_prot = arr_otp ? otp_lock                     // RL14
        : sfwp_blk_protected(psize, fr_addr[20:16]);          // RL12 RL18

    always_comb
    begin
        is_erase = 1'b1;
        er_kind = ERASE_SECTOR;
        er_bytes = BYTES_ERASE;
        er_cyc = 32'(SE_CYC - 1);
        er_prot = area_prot;
        case (fr_op)
            OP_SECTOR_ERASE: er_kind = ERASE_SECTOR;
            OP_BLOCK_ERASE_A, OP_BLOCK_ERASE_B:
            begin
                er_kind = ERASE_BLOCK;
                er_cyc = 32'(BE_CYC - 1);
            end
            OP_CHIP_ERASE_A, OP_CHIP_ERASE_B:
            begin
                er_kind = ERASE_CHIP;
                er_bytes = BYTES_ONE;
                er_cyc = 32'(CE_CYC - 1);
                er_prot = arr_otp | (psize != 3'h0);
            end
            default: is_erase = 1'b0;
        endcase
    end

    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_wel = write_enable_latch;
        next_psize = psize;
        next_srp = status_lock_bit;
        next_lock = otp_lock;
        next_otp = arr_otp;
        next_deep = deep_sleep;
        next_pend_sr = pend_sr;
        next_sr_data = sr_data;
        next_idx = idx;
        next_left = left;
        next_base = base;
        next_wr_en = 1'b0;
        next_addr = arr_addr;
        next_wr_data = arr_wr_data;
        next_erase = 1'b0;
        next_kind = arr_erase_kind;
        unique case (state)
            ST_IDLE:
            begin
                if (frame_done && deep_sleep)
                begin
                    if (fr_op == OP_WAKE)
                    begin
                        next_deep = 1'b0;                     // RL11
                    end
                end
                else if (frame_done)
                begin
                    case (fr_op)
                        OP_WRITE_ENABLE: next_wel = aligned ? 1'b1 : write_enable_latch;
                        OP_WRITE_DISABLE:
                        begin
                            if (aligned)
                            begin
                                next_wel = 1'b0;              // RL7
                                next_otp = 1'b0;
                            end
                        end
                        OP_OTP_ENTER: next_otp = aligned | arr_otp;
                        OP_DEEP_SLEEP: next_deep = aligned;
                        OP_STATUS_WRITE:
                        begin
                            if (write_ok && !hw_locked
                                && byte_cnt >= BYTES_STATUS_WRITE)  // RL13
                            begin
                                next_state = ST_WAIT;
                                next_cnt = 32'(STATUS_WRITE_CMD_CYC - 1);
                                next_pend_sr = 1'b1;
                                next_sr_data = fr_addr[7:0];
                            end
                        end
                        OP_PAGE_PROGRAM:
                        begin
                            if (write_ok && !area_prot
                                && byte_cnt >= BYTES_PP_MIN)  // RL21
                            begin
                                next_state = ST_PROG;
                                next_pend_sr = 1'b0;
                                next_idx = fr_addr[7:0];
                                next_base = fr_addr[20:8];
                                next_left = (data_bytes > BYTES_PAGE)
                                    ? 9'h100 : data_bytes[8:0];   // RL4
                            end
                        end
                        default:
                        begin
                            if (is_erase && write_ok && !er_prot
                                && byte_cnt == er_bytes)      // RL5 RL21
                            begin
                                next_state = ST_WAIT;
                                next_pend_sr = 1'b0;
                                next_cnt = er_cyc;
                                next_erase = 1'b1;
                                next_kind = er_kind;
                                next_addr = fr_addr[ADDR_W-1:0];
                            end
                        end
                    endcase
                end
            end
            ST_PROG:
            begin
                next_wr_en = 1'b1;
                next_addr = {base, idx};                      // RL22
                next_wr_data = page_buf[idx];
                next_idx = idx + 8'h01;
                next_left = left - 9'h001;
                if (left == 9'h001)
                begin
                    next_state = ST_WAIT;
                    next_cnt = 32'(PROG_CYC - 1);
                end
            end
            ST_WAIT:
            begin
                if (cnt == 32'h0000_0000)
                begin
                    next_state = ST_IDLE;
                    next_wel = 1'b0;                          // RL7
                    if (pend_sr && arr_otp)
                    begin
                        next_lock = 1'b1;                     // RL15
                    end
                    else if (pend_sr && !hw_locked)
                    begin
                        next_srp = sr_data[BIT_LOCK];
                        next_psize = sr_data[BIT_BP_HI:BIT_BP_LO];
                    end
                end
                else
                begin
                    next_cnt = cnt - 32'h0000_0001;
                end
            end
        endcase
        next_status = 8'h00;
        next_status[BIT_BUSY] = (next_state != ST_IDLE);      // RL8
        next_status[BIT_WEL] = next_wel;                      // RL9
        next_status[BIT_BP_HI:BIT_BP_LO] = next_psize;
        next_status[BIT_LOCK] = next_otp ? next_lock : next_srp;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cs_d <= 1'b1;
            seen_tog <= 1'b0;
            state <= ST_IDLE;
            cnt <= 32'h0000_0000;
            write_enable_latch <= 1'b0;
            psize <= PROTECT_SIZE_RESET;
            status_lock_bit <= STATUS_LOCK_RESET;
            otp_lock <= 1'b0;
            arr_otp <= 1'b0;
            deep_sleep <= 1'b0;
            pend_sr <= 1'b0;
            sr_data <= 8'h00;
            idx <= 8'h00;
            left <= 9'h000;
            base <= 13'h0000;
            arr_wr_en <= 1'b0;
            arr_addr <= '0;
            arr_wr_data <= 8'h00;
            arr_erase <= 1'b0;
            arr_erase_kind <= ERASE_SECTOR;
            status <= 8'h00;
            busy_flag <= 1'b0;
            active_mode <= 1'b0;
        end
        else
        begin
            cs_d <= cs_s;
            seen_tog <= (cs_s & ~cs_d) ? tog_s : seen_tog;
            state <= next_state;
            cnt <= next_cnt;
            write_enable_latch <= next_wel;
            psize <= next_psize;
            status_lock_bit <= next_srp;
            otp_lock <= next_lock;
            arr_otp <= next_otp;
            deep_sleep <= next_deep;
            pend_sr <= next_pend_sr;
            sr_data <= next_sr_data;
            idx <= next_idx;
            left <= next_left;
            base <= next_base;
            arr_wr_en <= next_wr_en;
            arr_addr <= next_addr;
            arr_wr_data <= next_wr_data;
            arr_erase <= next_erase;
            arr_erase_kind <= next_kind;
            status <= next_status;
            busy_flag <= (next_state != ST_IDLE);             // RL8
            active_mode <= ~cs_s | (next_state != ST_IDLE);   // RL10
        end
    end

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_wel_gate: assert property (frame_done && !write_enable_latch && state == ST_IDLE
        |=> state == ST_IDLE) else $error("cycle began without latch"); // RL6
    a_busy_span: assert property (state != ST_IDLE
        |-> busy_flag && status[BIT_BUSY]) else $error("busy low in cycle"); // RL8
    a_wel_drop: assert property (state == ST_WAIT && cnt == 0
        |=> !write_enable_latch && state == ST_IDLE) else $error("latch kept at end"); // RL7
    a_sleep_deaf: assert property (deep_sleep && frame_done
        && fr_op != OP_WAKE |=> deep_sleep && $stable(write_enable_latch)
        && state == ST_IDLE) else $error("sleep obeyed command"); // RL11
    a_protect_refuse: assert property (frame_done && state == ST_IDLE
        && area_prot && fr_op == OP_PAGE_PROGRAM |=> state == ST_IDLE
        && !arr_wr_en) else $error("program into protected area"); // RL21
    a_align_check: assert property (frame_done && !aligned // RL17
        && state == ST_IDLE |=> state == ST_IDLE && $stable(write_enable_latch))
        else $error("odd frame ran");
    a_hw_freeze: assert property (hw_locked && !arr_otp
        |=> $stable(psize) && $stable(status_lock_bit)) else $error("frozen bits moved"); // RL13
    a_page_stay: assert property (arr_wr_en && $past(arr_wr_en)
        |-> arr_addr[ADDR_W-1:8] == $past(arr_addr[ADDR_W-1:8]))
        else $error("program left its page"); // RL22
    a_lock_keep: assert property (otp_lock |=> otp_lock)
        else $error("otp lock cleared"); // RL14
    a_active_sel: assert property (!cs_s |=> active_mode)
        else $error("inactive while selected"); // RL10

    c_program: cover property (state == ST_PROG ##1 state == ST_WAIT);
    c_erase: cover property (arr_erase && arr_erase_kind == ERASE_BLOCK);
    c_sleep: cover property (deep_sleep ##1 !deep_sleep);
    c_otp_lock: cover property (!otp_lock ##1 otp_lock);
endmodule
`default_nettype wire

// *** design/sfwp_pkg.sv ***
// shared constants and types for the serial flash protect controller
package sfwp_pkg;

    // array organisation
    localparam int ADDR_W = 21;
    localparam int PAGE_BYTES = 256;
    localparam int SECTOR_BYTES = 4096;
    localparam int BLOCK_BYTES = 65536;
    localparam int SECTOR_COUNT = 512;
    localparam int BLOCK_COUNT = 32;

    // operation codes
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] OP_BLOCK_ERASE_A = 8'hD8;
    localparam logic [7:0] OP_BLOCK_ERASE_B = 8'h52;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'hC7;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
    localparam logic [7:0] OP_DEEP_SLEEP = 8'hB9;
    localparam logic [7:0] OP_WAKE = 8'hAB;
    localparam logic [7:0] OP_OTP_ENTER = 8'h3A;

    // frame length checks, in whole bytes including the opcode
    localparam logic [9:0] BYTES_ONE = 10'h001;
    localparam logic [9:0] BYTES_STATUS_WRITE = 10'h002;
    localparam logic [9:0] BYTES_ERASE = 10'h004;
    localparam logic [9:0] BYTES_PP_HEADER = 10'h004;
    localparam logic [9:0] BYTES_PP_MIN = 10'h005;
    localparam logic [9:0] BYTES_MAX = 10'h3FF;
    localparam logic [9:0] BYTES_PAGE = 10'h100;

    // status byte layout
    localparam int BIT_BUSY = 0;
    localparam int BIT_WEL = 1;
    localparam int BIT_BP_LO = 2;
    localparam int BIT_BP_HI = 4;
    localparam int BIT_LOCK = 7;
    localparam logic [2:0] PROTECT_SIZE_RESET = 3'h0;
    localparam logic STATUS_LOCK_RESET = 1'b0;

    // lowest protected block for each protect size code
    localparam logic [5:0] FLOOR_ALL = 6'h00;
    localparam logic [5:0] FLOOR_HALF = 6'h10;
    localparam logic [5:0] FLOOR_QUARTER = 6'h18;
    localparam logic [5:0] FLOOR_EIGHTH = 6'h1C;
    localparam logic [5:0] FLOOR_SIXTEENTH = 6'h1E;
    localparam logic [5:0] FLOOR_TOP = 6'h1F;
    localparam logic [5:0] FLOOR_NONE = 6'h20;

    // erase kinds
    localparam logic [1:0] ERASE_SECTOR = 2'h0;
    localparam logic [1:0] ERASE_BLOCK = 2'h1;
    localparam logic [1:0] ERASE_CHIP = 2'h2;

    // internal cycle times and their counts at the system clock
    localparam int CLK_MHZ = 25;
    localparam int PROGRAM_CYCLE_TIME_US = 1500;
    localparam int SECTOR_ERASE_TIME_MS = 150;
    localparam int BLOCK_ERASE_TIME_MS = 800;
    localparam int CHIP_ERASE_TIME_S = 18;
    localparam int STATUS_WRITE_TIME_US = 10;
    localparam int PROGRAM_CYC = PROGRAM_CYCLE_TIME_US * CLK_MHZ;
    localparam int SECTOR_ERASE_CYC = SECTOR_ERASE_TIME_MS * 1000 * CLK_MHZ;
    localparam int BLOCK_ERASE_CYC = BLOCK_ERASE_TIME_MS * 1000 * CLK_MHZ;
    localparam int CHIP_ERASE_CYC = CHIP_ERASE_TIME_S * 1000000 * CLK_MHZ;
    localparam int STATUS_WRITE_CYC = STATUS_WRITE_TIME_US * CLK_MHZ;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_PROG = 3'h2,
        ST_WAIT = 3'h4
    } sfwp_state_e;

    // block lies inside the protected upper region
    function automatic logic sfwp_blk_protected(input logic [2:0] size,
                                                input logic [4:0] blk);
        logic [5:0] floor_blk;
        floor_blk = FLOOR_NONE;
        unique case (size)
            3'h7, 3'h6: floor_blk = FLOOR_ALL;
            3'h5: floor_blk = FLOOR_HALF;
            3'h4: floor_blk = FLOOR_QUARTER;
            3'h3: floor_blk = FLOOR_EIGHTH;
            3'h2: floor_blk = FLOOR_SIXTEENTH;
            3'h1: floor_blk = FLOOR_TOP;
            3'h0: floor_blk = FLOOR_NONE;
        endcase
        return {1'b0, blk} >= floor_blk;
    endfunction

endpackage

// *** design/sfwp_sync.sv ***
// two-flop level synchroniser
`timescale 1ns/1ns
`default_nettype none
module sfwp_sync
    import sfwp_pkg::*;
#(
    parameter int W = 1
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta <= '0;
            dout <= '0;
        end
        else
        begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule
`default_nettype wire

// *** test/sfwp_master.sv ***
// spi master model for the serial flash link
`timescale 1ns/1ns
`default_nettype none
module sfwp_master (
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input wire logic miso,
    input wire logic mode3
);
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // one frame, msb first, keeps last 8 bits read
    task automatic frame(input int nbits, input logic [47:0] tx,
                         output logic [7:0] rx);
        sclk = mode3;
        #10 cs_n = 1'b0;
        for (int i = nbits - 1; i >= 0; i--)
        begin
            #7 sclk = 1'b0;
            mosi = tx[i];
            #8 sclk = 1'b1;
            rx = {rx[6:0], miso};
        end
        #7 sclk = mode3;
        #8 cs_n = 1'b1;
        mosi = ~mosi;
    endtask
endmodule
`default_nettype wire

// *** test/tb_sfwp_ctrl.sv ***
// testbench for the serial flash protect controller
`timescale 1ns/1ns
`default_nettype none
module tb_sfwp_ctrl
    import sfwp_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic wp_n = 1'b1;
    logic mode3 = 1'b0;
    logic sclk, cs_n, mosi, so, so_en, wr_en, er, busy, act, dsl, otp;
    logic [ADDR_W-1:0] addr, last_a;
    logic [7:0] wdat, last_d, rx;
    logic [1:0] ekind;
    int fail_count = 0;
    int n_checks = 0;
    int n_wr = 0;
    int n_er = 0;
    int c0;
    always #20 mclk = ~mclk;
    sfwp_ctrl #(.PROG_CYC(20), .SE_CYC(20), .BE_CYC(20), .CE_CYC(20),
        .STATUS_WRITE_CMD_CYC(20)) dut (.mclk(mclk), .rst_n(rst_n), .sclk(sclk),
        .cs_n(cs_n), .serial_in(mosi), .wp_n(wp_n), .serial_out(so),
        .serial_out_en(so_en), .arr_wr_en(wr_en), .arr_addr(addr),
        .arr_wr_data(wdat), .arr_erase(er), .arr_erase_kind(ekind),
        .arr_otp(otp), .busy_flag(busy), .active_mode(act),
        .deep_sleep(dsl));
    // pull-up on the released data line
    sfwp_master m (.sclk(sclk), .cs_n(cs_n), .mosi(mosi),
        .miso(so_en ? so : 1'b1), .mode3(mode3));
    always @(posedge mclk)
    begin
        if (wr_en === 1'b1)
        begin
            n_wr <= n_wr + 1;
            last_a <= addr;
            last_d <= wdat;
        end
        if (er === 1'b1)
            n_er <= n_er + 1;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmd(input int n, input logic [47:0] tx);
        m.frame(n, tx, rx);
        repeat (8) @(negedge mclk);
    endtask
    task automatic rdsr(input logic [7:0] exp);
        cmd(16, {OP_READ_STATUS, 8'h00});
        chk(rx, exp);
    endtask
    task automatic waitbusy();
        repeat (60) if (busy === 1'b1) @(negedge mclk);
    endtask
    task automatic wsr(input logic [7:0] v);
        cmd(8, OP_WRITE_ENABLE);
        cmd(16, {OP_STATUS_WRITE, v});
        waitbusy();
    endtask
    task automatic t_status();
        rdsr(8'h00);
        cmd(8, OP_WRITE_ENABLE);
        mode3 = 1'b1;
        rdsr(8'h02);
        cmd(8, OP_WRITE_DISABLE);
        rdsr(8'h00);
        mode3 = 1'b0;
    endtask
    task automatic t_program();
        cmd(8, OP_WRITE_ENABLE);
        c0 = n_wr;
        cmd(48, {OP_PAGE_PROGRAM, 24'h00_00FF, 8'hA5, 8'h5A});
        chk(n_wr - c0, 2);
        chk(last_a, 21'h00_0000);
        chk(last_d, 8'h5A);
        chk(busy, 1'b1);
        chk(act, 1'b1);
        waitbusy();
        rdsr(8'h00);
        chk(act, 1'b0);
    endtask
    task automatic t_refuse();
        c0 = n_wr;
        cmd(40, {OP_PAGE_PROGRAM, 24'h00_0010, 8'h00});
        chk(n_wr - c0, 0);
        cmd(7, 7'h03);
        rdsr(8'h00);
        cmd(8, OP_WRITE_ENABLE);
        cmd(17, {OP_STATUS_WRITE, 8'h1C, 1'b0});
        rdsr(8'h02);
        cmd(8, OP_WRITE_DISABLE);
    endtask
    task automatic t_protect();
        wsr(8'h04);
        rdsr(8'h04);
        cmd(8, OP_WRITE_ENABLE);
        c0 = n_er;
        cmd(32, {OP_SECTOR_ERASE, 24'h1F_0000});
        chk(n_er - c0, 0);
        cmd(32, {OP_BLOCK_ERASE_B, 24'h00_0000});
        chk(ekind, ERASE_BLOCK);
        waitbusy();
        cmd(8, OP_WRITE_ENABLE);
        cmd(32, {OP_SECTOR_ERASE, 24'h1E_0000});
        chk(n_er - c0, 2);
        chk(ekind, ERASE_SECTOR);
        waitbusy();
        wsr(8'h84);
        wp_n = 1'b0;
        wsr(8'h00);
        rdsr(8'h86);
        chk(rx & 8'hFC, 8'h84);
        wp_n = 1'b1;
        wsr(8'h00);
        rdsr(8'h00);
    endtask
    task automatic t_sleep();
        cmd(8, OP_DEEP_SLEEP);
        chk(dsl, 1'b1);
        cmd(8, OP_WRITE_ENABLE);
        cmd(8, OP_WAKE);
        chk(dsl, 1'b0);
        rdsr(8'h00);
    endtask
    task automatic t_otp();
        wsr(8'h00);
        cmd(8, OP_OTP_ENTER);
        chk(otp, 1'b1);
        cmd(8, OP_WRITE_ENABLE);
        c0 = n_wr;
        cmd(40, {OP_PAGE_PROGRAM, 24'h00_0020, 8'h3C});
        chk(n_wr - c0, 1);
        waitbusy();
        wsr(8'h00);
        rdsr(8'h80);
        cmd(8, OP_WRITE_ENABLE);
        cmd(40, {OP_PAGE_PROGRAM, 24'h00_0020, 8'h3C});
        chk(n_wr - c0, 1);
        cmd(8, OP_WRITE_DISABLE);
        chk(otp, 1'b0);
        rdsr(8'h00);
    endtask
    task automatic results();
        $display("checks=%0d fails=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        #400_000;
        fail_count++;
        results();
    end
    initial
    begin
        repeat (10) @(negedge mclk);
        rst_n = 1'b1;
        repeat (4) @(negedge mclk);
        t_status();
        t_program();
        t_refuse();
        t_protect();
        t_sleep();
        t_otp();
        results();
    end
endmodule
`default_nettype wire
